// file: bench/adc_seq_asserts.sv
/*
  Port-level checks of the conversion-sequence controller.
  Assumes a bind onto adc_sequence_start_control; one clock domain.
*/
`timescale 1ns/100ps

module adc_seq_asserts
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // converter and result
  input wire logic        conv_start_q,
  input wire logic        conv_abort_q,
  input wire logic [3:0]  conv_channel_q,
  input wire logic        conv_res8_q,
  input wire logic [9:0]  conv_raw,
  input wire logic [15:0] result_q,
  input wire logic        result_valid_q
);
  logic [7:0] ctrl_q;
  logic       trig_q;
  wire        wr   = psel && penable && pready_q && pwrite && !pslverr_q;
  wire        wr_c = wr && paddr == adc_seq_pkg::SEQ_CTRL_OFFSET;
  wire        wr_f = wr && paddr == adc_seq_pkg::SEQ_CONFIG_OFFSET;

  // shadow of written settings, so result formats can be predicted
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_q <= 8'h00;
      trig_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= wr_c ? pwdata[7:0] : ctrl_q;
      trig_q <= wr_f ? pwdata[0] : trig_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_READY_WAIT: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready_q ##1 pready_q)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready_q |=> !pready_q)
    else $error("pready held longer than one cycle");
  AST_UNMAPPED: assert property (pslverr_q |-> pready_q && (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
    else $error("slave error on a mapped address");
  AST_CTRL_START: assert property (wr_c && !trig_q |=> conv_start_q)
    else $error("control write did not start a conversion");
  AST_ARMED_WAIT: assert property (wr_c && trig_q |=> !conv_start_q)
    else $error("armed control write started a conversion");
  AST_ABORT_CAUSE: assert property (conv_abort_q |-> $past(wr_c))
    else $error("abort without a control write");
  AST_ONE_CHAN: assert property (conv_start_q && !ctrl_q[4] |-> conv_channel_q == ctrl_q[3:0])
    else $error("single-channel start on wrong channel");
  AST_LEFT10: assert property (result_valid_q && ctrl_q[7:6] == 2'b00 && !conv_res8_q
      |-> result_q == {$past(conv_raw), 6'h00})
    else $error("10-bit left result misplaced");
  AST_SIGNED10: assert property (result_valid_q && ctrl_q[7:6] == 2'b01 && !conv_res8_q
      |-> result_q == {$past(conv_raw) ^ 10'h200, 6'h00})
    else $error("10-bit signed result wrong");
  AST_RIGHT8: assert property (result_valid_q && ctrl_q[7] && conv_res8_q
      |-> result_q == {6'h00, $past(conv_raw) & 10'h0ff})
    else $error("8-bit right result wrong");
  AST_RIGHT10: assert property (result_valid_q && ctrl_q[7] && !conv_res8_q
      |-> result_q == {6'h00, $past(conv_raw)})
    else $error("10-bit right result wrong");
endmodule : adc_seq_asserts

bind adc_sequence_start_control adc_seq_asserts u_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .conv_start_q(conv_start_q), .conv_abort_q(conv_abort_q),
  .conv_channel_q(conv_channel_q), .conv_res8_q(conv_res8_q), .conv_raw(conv_raw),
  .result_q(result_q), .result_valid_q(result_valid_q));

// file: bench/adc_sequence_start_control_bench.sv
/*
  Self-checking bench: apb tasks, a converter stand-in and a verdict.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps

module adc_sequence_start_control_bench;
  localparam logic [11:0] CTRL = adc_seq_pkg::SEQ_CTRL_OFFSET;
  localparam logic [11:0] CFG  = adc_seq_pkg::SEQ_CONFIG_OFFSET;
  localparam logic [11:0] STAT = adc_seq_pkg::SEQ_STATUS_OFFSET;
  logic        clk, reset_n, psel, penable, pwrite, hw_trigger, conv_done, err;
  logic        pready_q, pslverr_q, conv_start_q, conv_abort_q, conv_res8_q, result_valid_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, q;
  logic [3:0]  conv_channel_q, result_index_q, c;
  logic [9:0]  conv_raw, raw;
  logic [15:0] result_q;
  int          num_errors, samples_checked, aborts, s, i, k;

  adc_sequence_start_control DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .hw_trigger(hw_trigger), .conv_start_q(conv_start_q),
    .conv_abort_q(conv_abort_q), .conv_channel_q(conv_channel_q), .conv_res8_q(conv_res8_q),
    .conv_done(conv_done), .conv_raw(conv_raw), .result_q(result_q),
    .result_valid_q(result_valid_q), .result_index_q(result_index_q));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (conv_abort_q === 1'b1) aborts <= aborts + 1;

  task print_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task timeout();
    num_errors++;
    print_verdict();
  endtask : timeout

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready_q !== 1'b1; n++)
      @(posedge clk);
    if (n == 20) timeout();
    q = prdata_q;
    err = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // the next start may share the cycle of the last result, so test before waiting
  task conv(input logic [9:0] r, input logic [3:0] ch, input logic [3:0] ix, input logic [15:0] e);
    int n;
    for (n = 0; n < 40 && conv_start_q !== 1'b1; n++)
      @(posedge clk);
    if (n == 40) timeout();
    check({28'h0, conv_channel_q}, {28'h0, ch});
    conv_done <= 1'b1;
    conv_raw  <= r;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_raw  <= ~r;
    for (n = 0; n < 20 && result_valid_q !== 1'b1; n++)
      @(posedge clk);
    if (n == 20) timeout();
    check({16'h0, result_q}, {16'h0, e});
    check({28'h0, result_index_q}, {28'h0, ix});
  endtask : conv

  task quiet(input int cyc);
    s = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      if (conv_start_q === 1'b1) s++;
    end
  endtask : quiet

  // two-cycle pin pulse, long enough for the two-stage synchroniser
  task pulse();
    @(posedge clk);
    hw_trigger <= 1'b1;
    repeat (2) @(posedge clk);
    hw_trigger <= 1'b0;
  endtask : pulse

  // m is {res8, right, signed}
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic [2:0] m);
    if (m[1]) return m[2] ? {8'h00, r[7:0]} : {6'h00, r};
    return (m[2] ? {r[7:0], 8'h00} : {r, 6'h00}) ^ {m[0], 15'h0};
  endfunction : fmt

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hw_trigger = 1'b0;
    conv_done = 1'b0;
    conv_raw = 10'h000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    check(q, {24'h0, adc_seq_pkg::SEQ_CTRL_RESET});
    apb(1'b0, 12'h010, 32'h0);
    check({q[30:0], err}, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      raw = 10'h2c5 + 10'(i);
      apb(1'b1, CFG, {20'h0, 4'h1, 4'hf, 2'b00, i[2], 1'b0});
      apb(1'b1, CTRL, {24'h0, i[1:0], 2'b00, i[3:0]});
      conv(raw, i[3:0], 4'h0, fmt(raw, i[2:0]));
      check({31'h0, conv_res8_q}, {31'h0, i[2]});
      apb(1'b0, STAT, 32'h0);
      check(q & 32'h1bf, 32'h80);
      apb(1'b0, CTRL, 32'h0);
      check(q, {24'h0, i[1:0], 2'b00, i[3:0]});
    end
    apb(1'b1, CFG, 32'h430);
    for (k = 0; k < 2; k++)
    begin
      c = k ? 4'h2 : 4'he;
      apb(1'b1, CTRL, {24'h0, 4'h1, c});
      for (i = 0; i < 4; i++)
      begin
        raw = {c, 6'h2a};
        conv(raw, c, i[3:0], {raw, 6'h00});
        c = (c == 4'h3) ? 4'h0 : c + 4'h1;
      end
    end
    // two conversions a sequence, so the abort lands with the counter at one
    apb(1'b1, CFG, 32'h2f0);
    apb(1'b1, CTRL, 32'h27);
    conv(10'h155, 4'h7, 4'h0, 16'h5540);
    conv(10'h155, 4'h7, 4'h1, 16'h5540);
    for (k = 0; k < 20 && conv_start_q !== 1'b1; k++)
      @(posedge clk);
    check({31'h0, conv_start_q}, 32'h1);
    conv(10'h155, 4'h7, 4'h0, 16'h5540);
    apb(1'b1, CTRL, 32'h07);
    conv(10'h0aa, 4'h7, 4'h0, 16'h2a80);
    conv(10'h0aa, 4'h7, 4'h1, 16'h2a80);
    check(aborts, 1);
    quiet(12);
    check(s, 0);
    apb(1'b1, CFG, 32'h1f1);
    apb(1'b1, CTRL, 32'h23);
    quiet(12);
    check(s, 0);
    apb(1'b0, STAT, 32'h0);
    check(q & 32'ha0, 32'h0);
    // two triggers: each must give exactly one single-conversion sequence
    for (k = 0; k < 2; k++)
    begin
      pulse();
      conv(10'h3c3, 4'h3, 4'h0, 16'hf0c0);
      quiet(12);
      check(s, 0);
    end
    apb(1'b0, adc_seq_pkg::SEQ_RESULT_OFFSET, 32'h0);
    check(q, 32'h0000f0c0);
    // a trigger while converting flags an overrun; a control write clears it
    pulse();
    for (k = 0; k < 20 && conv_start_q !== 1'b1; k++)
      @(posedge clk);
    pulse();
    repeat (4) @(posedge clk);
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h23);
    apb(1'b0, STAT, 32'h0);
    check(q & 32'h120, 32'h120);
    apb(1'b1, CTRL, 32'h23);
    apb(1'b0, STAT, 32'h0);
    check(q & 32'h1a0, 32'h0);
    check(aborts, 2);
    print_verdict();
  end
endmodule : adc_sequence_start_control_bench

// file: rtl/adc_seq_pkg.sv
/*
  Constants shared by the conversion-sequence controller and its result
  formatter: APB offsets, field positions, reset values and widths.
  Assumes a 32-bit APB with one aligned word per register.
*/
package adc_seq_pkg;

  // apb map, byte addresses
  localparam logic [11:0] SEQ_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] SEQ_CONFIG_OFFSET = 12'h004;
  localparam logic [11:0] SEQ_STATUS_OFFSET = 12'h008;
  localparam logic [11:0] SEQ_RESULT_OFFSET = 12'h00c;

  // conversion_sequence_control fields
  localparam int JUSTIFY_BIT    = 7;
  localparam int SIGNED_BIT     = 6;
  localparam int CONTINUOUS_BIT = 5;
  localparam int MULTI_BIT      = 4;
  localparam int CHAN_MSB       = 3;
  localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;

  // configuration fields
  localparam int TRIG_EN_BIT  = 0;
  localparam int RES_SEL_BIT  = 1;
  localparam int WRAP_LSB     = 4;
  localparam int WRAP_MSB     = 7;
  localparam int LEN_LSB      = 8;
  localparam int LEN_MSB      = 11;
  localparam logic [3:0] WRAP_RESET = 4'hf;
  localparam logic [3:0] LEN_RESET  = 4'h0;

  // status fields
  localparam int COMPLETE_BIT = 7;
  localparam int OVERRUN_BIT  = 5;
  localparam int BUSY_BIT     = 8;
  localparam int COUNT_MSB    = 3;

  // widths
  localparam int RAW_W    = 10;
  localparam int RESULT_W = 16;
  localparam int CHAN_W   = 4;

  // trigger synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage : adc_seq_pkg

// file: rtl/adc_sequence_start_control.sv
/*
  Conversion-sequence controller of a 16-input, 10-bit converter sequencer,
  with its APB register slave, trigger input, converter handshake and result
  word output.
  Assumes a converter core that begins sampling on conv_start_q, returns one
  conv_done pulse with conv_raw valid per conversion, and stops on
  conv_abort_q. The trigger pin is asynchronous to clk.
*/
`timescale 1ns/100ps

// Behaviour
// - control register write aborts any sequence and, without hardware trigger, starts a new one
// - with hardware trigger, one control write arms; each trigger runs a sequence (a trigger during a sequence only sets overrun)
// - conversion start marks the first cycle of its sampling phase
// - bit 7: zero left-justifies results, one right-justifies them
// - bit 6: zero unsigned results, one two's complement signed results
// - right justification forces unsigned results, ignoring the signed bit
// - bit 5: zero runs one sequence, one repeats sequences continuously
// - hardware trigger ignores continuous bit; one sequence per trigger
// - bit 4 zero: every conversion samples the selected channel
// - bit 4 one: step across channels, count from sequence length
// - bits 3:0 channel code 0..15; first channel in multi mode
// - next channel is code plus one; after wrap channel go to zero
// - start above wrap channel: first wrap happens after input fifteen
// - 8-bit results sit in bits 15:8 left or 7:0 right
// - 10-bit results sit in bits 15:6 left or 9:0 right
// - control register is readable and writable at any time
// - resolution select zero gives 10-bit, one gives 8-bit results
// - control write clears sequence complete and trigger overrun flags
// - control write resets the conversion counter to zero
module adc_sequence_start_control
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata_q,
  output      logic        pready_q,
  output      logic        pslverr_q,
  // external trigger pin
  input  wire logic        hw_trigger,
  // converter core handshake
  output      logic        conv_start_q,
  output      logic        conv_abort_q,
  output      logic [3:0]  conv_channel_q,
  output      logic        conv_res8_q,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_raw,
  // placed result
  output      logic [15:0] result_q,
  output      logic        result_valid_q,
  output      logic [3:0]  result_index_q
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_CONVERT
  } state_t;

  state_t      state_q;
  state_t      state_d;

  // register state
  logic [7:0]  ctrl_q;
  logic        trig_en_q;
  logic        res8_q;
  logic [3:0]  wrap_q;
  logic [3:0]  len_q;
  logic        complete_q;
  logic        overrun_q;
  logic [3:0]  count_q;
  logic [3:0]  count_d;
  logic [3:0]  chan_d;
  logic        start_d;
  logic        complete_d;
  logic        overrun_d;

  // trigger synchroniser
  logic        trig_meta_q;
  logic        trig_sync_q;
  logic        trig_prev_q;
  logic        trig_edge;

  // apb decode
  logic        apb_access;
  logic        apb_write;
  logic        apb_read_phase;
  logic        hit_ctrl;
  logic        hit_config;
  logic        hit_status;
  logic        hit_result;
  logic        addr_ok;
  logic        ctrl_write;
  logic        config_write;
  logic        status_write;
  logic [31:0] read_word;

  // sequence decode
  logic        busy;
  logic        last_conv;
  logic [3:0]  next_chan;
  logic [15:0] formatted;
  logic        repeat_seq;

  // a write lands only on the edge where pready is seen high
  assign apb_access     = psel & penable & pready_q;
  assign apb_write      = apb_access & pwrite;
  assign apb_read_phase = psel & penable & ~pready_q;

  assign hit_ctrl   = paddr == adc_seq_pkg::SEQ_CTRL_OFFSET;
  assign hit_config = paddr == adc_seq_pkg::SEQ_CONFIG_OFFSET;
  assign hit_status = paddr == adc_seq_pkg::SEQ_STATUS_OFFSET;
  assign hit_result = paddr == adc_seq_pkg::SEQ_RESULT_OFFSET;
  assign addr_ok    = hit_ctrl | hit_config | hit_status | hit_result;

  // no busy gating: accepted in every state
  assign ctrl_write   = apb_write & hit_ctrl;
  assign config_write = apb_write & hit_config;
  assign status_write = apb_write & hit_status;

  assign busy = state_q == ST_CONVERT;

  assign read_word = hit_ctrl   ? {24'h000000, ctrl_q} :
                     hit_config ? {20'h00000, len_q, wrap_q, 2'b00, res8_q, trig_en_q} :
                     hit_status ? {23'h0, busy, complete_q, 1'b0, overrun_q, 1'b0, count_q} :
                     hit_result ? {16'h0000, result_q} :
                                  32'h00000000;

  // trigger pin: only the second stage is looked at
  assign trig_edge = trig_sync_q & ~trig_prev_q;

  // length code zero means sixteen conversions
  assign last_conv = count_q == (len_q - 4'h1);

  // plain 4-bit increment already wraps fifteen to zero
  assign next_chan = (conv_channel_q == wrap_q) ? 4'h0 : (conv_channel_q + 4'h1);

  // trigger mode never repeats on its own
  assign repeat_seq = ctrl_q[adc_seq_pkg::CONTINUOUS_BIT] & ~trig_en_q;

  result_formatter u_result_formatter
  (
    .raw           (conv_raw),
    .res8          (res8_q),
    .justify_right (ctrl_q[adc_seq_pkg::JUSTIFY_BIT]),
    .signed_sel    (ctrl_q[adc_seq_pkg::SIGNED_BIT]),
    .result        (formatted)
  );

  // sequencer next state
  always_comb
  begin
    state_d    = state_q;
    count_d    = count_q;
    chan_d     = conv_channel_q;
    start_d    = 1'b0;
    complete_d = complete_q;
    overrun_d  = overrun_q;
    if (status_write && pwdata[adc_seq_pkg::COMPLETE_BIT])
    begin
      complete_d = 1'b0;
    end
    if (status_write && pwdata[adc_seq_pkg::OVERRUN_BIT])
    begin
      overrun_d = 1'b0;
    end
    if (ctrl_write)
    begin
      complete_d = 1'b0;
      overrun_d  = 1'b0;
      count_d    = 4'h0;
      chan_d     = pwdata[adc_seq_pkg::CHAN_MSB:0];
      if (trig_en_q)
      begin
        state_d = ST_WAIT_TRIG;
      end
      else
      begin
        state_d = ST_CONVERT;
        start_d = 1'b1;
      end
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          state_d = ST_IDLE;
        end
        ST_WAIT_TRIG:
        begin
          if (!trig_en_q)
          begin
            state_d = ST_IDLE;
          end
          else if (trig_edge)
          begin
            state_d = ST_CONVERT;
            start_d = 1'b1;
            count_d = 4'h0;
            chan_d  = ctrl_q[adc_seq_pkg::CHAN_MSB:0];
          end
        end
        ST_CONVERT:
        begin
          if (trig_edge && trig_en_q)
          begin
            overrun_d = 1'b1;
          end
          if (conv_done)
          begin
            if (ctrl_q[adc_seq_pkg::MULTI_BIT])
            begin
              chan_d = next_chan;
            end
            if (last_conv)
            begin
              complete_d = 1'b1;
              count_d    = 4'h0;
              if (ctrl_q[adc_seq_pkg::MULTI_BIT])
              begin
                chan_d = ctrl_q[adc_seq_pkg::CHAN_MSB:0];
              end
              if (trig_en_q)
              begin
                state_d = ST_WAIT_TRIG;
              end
              else if (repeat_seq)
              begin
                start_d = 1'b1;
              end
              else
              begin
                state_d = ST_IDLE;
              end
            end
            else
            begin
              count_d = count_q + 4'h1;
              start_d = 1'b1;
            end
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // trigger synchroniser and edge history
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_meta_q <= hw_trigger;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  // software-visible settings
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_q    <= adc_seq_pkg::SEQ_CTRL_RESET;
      trig_en_q <= 1'b0;
      res8_q    <= 1'b0;
      wrap_q    <= adc_seq_pkg::WRAP_RESET;
      len_q     <= adc_seq_pkg::LEN_RESET;
    end
    else
    begin
      if (ctrl_write)
      begin
        ctrl_q <= pwdata[7:0];
      end
      if (config_write)
      begin
        trig_en_q <= pwdata[adc_seq_pkg::TRIG_EN_BIT];
        res8_q    <= pwdata[adc_seq_pkg::RES_SEL_BIT];
        wrap_q    <= pwdata[adc_seq_pkg::WRAP_MSB:adc_seq_pkg::WRAP_LSB];
        len_q     <= pwdata[adc_seq_pkg::LEN_MSB:adc_seq_pkg::LEN_LSB];
      end
    end
  end

  // sequencer state and converter handshake
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q        <= ST_IDLE;
      count_q        <= 4'h0;
      complete_q     <= 1'b0;
      overrun_q      <= 1'b0;
      conv_channel_q <= 4'h0;
      conv_start_q   <= 1'b0;
      conv_abort_q   <= 1'b0;
      conv_res8_q    <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      count_q        <= count_d;
      complete_q     <= complete_d;
      overrun_q      <= overrun_d;
      conv_channel_q <= chan_d;
      conv_start_q   <= start_d;
      conv_abort_q   <= ctrl_write & busy;
      conv_res8_q    <= res8_q;
    end
  end

  // result capture; a done pulse in the cycle of a control write is dropped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      result_q       <= 16'h0000;
      result_valid_q <= 1'b0;
      result_index_q <= 4'h0;
    end
    else
    begin
      result_valid_q <= busy & conv_done & ~ctrl_write;
      if (busy && conv_done && !ctrl_write)
      begin
        result_q       <= formatted;
        result_index_q <= count_q;
      end
    end
  end

  // apb answer: one wait state, data held from the access phase
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= apb_read_phase;
      pslverr_q <= apb_read_phase & ~addr_ok;
      if (apb_read_phase)
      begin
        prdata_q <= pwrite ? 32'h00000000 : read_word;
      end
    end
  end

endmodule : adc_sequence_start_control

// file: rtl/result_formatter.sv
/*
  Combinational placement of a raw conversion code into a 16-bit result
  word: justification, signed form and 8/10-bit width.
  Assumes the converter delivers 10-bit codes in raw[9:0] and 8-bit codes
  in raw[7:0].
*/
`timescale 1ns/100ps

module result_formatter
(
  // raw code and format controls
  input  wire logic [adc_seq_pkg::RAW_W-1:0]    raw,
  input  wire logic                             res8,
  input  wire logic                             justify_right,
  input  wire logic                             signed_sel,
  // placed result
  output      logic [adc_seq_pkg::RESULT_W-1:0] result
);

  logic                                 use_signed;
  logic [7:0]                           code8;
  logic [adc_seq_pkg::RAW_W-1:0]        code10;
  logic [adc_seq_pkg::RESULT_W-1:0]     left8;
  logic [adc_seq_pkg::RESULT_W-1:0]     left10;
  logic [adc_seq_pkg::RESULT_W-1:0]     right8;
  logic [adc_seq_pkg::RESULT_W-1:0]     right10;

  // right justification is always unsigned
  assign use_signed = signed_sel & ~justify_right;

  // signed form flips the top code bit, mid-scale reads zero
  assign code8  = {raw[7] ^ use_signed, raw[6:0]};
  assign code10 = {raw[9] ^ use_signed, raw[8:0]};

  assign left8   = {code8, 8'h00};
  assign right8  = {8'h00, raw[7:0]};
  assign left10  = {code10, 6'h00};
  assign right10 = {6'h00, raw};

  assign result = res8 ? (justify_right ? right8 : left8)
                       : (justify_right ? right10 : left10);

endmodule : result_formatter
